// File: shared/sts_regs.svh
/*
 * constants for the serial target unit: field positions, reset values, widths, depths.
 * assumes inclusion by bare name from package and rtl files.
 */
`ifndef STS_REGS_SVH
`define STS_REGS_SVH

`define STS_CNT_W          13
`define STS_ADDR_W         32
`define STS_FIFO_DEPTH     16
`define STS_FIFO_AW        4
`define STS_CFG_ORDER_BIT  0
`define STS_CFG_CPHA_BIT   1
`define STS_CFG_CPOL_BIT   2
`define STS_CFG_RESET      3'h0
`define STS_FILL_RESET     8'h00

`endif

// File: shared/sts_pkg.sv
/*
 * types for the serial target unit.
 * assumes sts_regs.svh is on the include path.
 */
`include "sts_regs.svh"

package sts_pkg;
    typedef enum logic [1:0] {SEM_FREE, SEM_CPU, SEM_TARGET} sts_sem_type;
    typedef enum logic [1:0] {XF_IDLE, XF_GRANTED, XF_IGNORED} sts_xfer_type;
endpackage

// File: rtl/sts_fifo.sv
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes a single clock and a synchronous flush.
 */
module sts_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             flush_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // compare at full count width: a narrow cast of the depth wraps to zero
    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH)) && !flush_i;
    assign out_valid_o = (cnt_q != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i && !flush_i;
    assign out_data_o  = mem_q[rp_q];

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_q[wp_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else if (flush_i)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop)
            begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: rtl/sts_shifter.sv
/*
 * serial shift engine: finds sampled sck edges, shifts bytes in and out in all four modes.
 * assumes sck/mosi/csn already synchronised to clk_i; lengths of 8 bits.
 */
module sts_shifter (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       active_i,
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    input  wire logic       lsb_first_i,
    input  wire logic [7:0] tx_byte_i,
    output logic            tx_load_o,
    output logic            miso_o,
    output logic      [7:0] rx_byte_o,
    output logic            rx_done_o
);
    logic       sck_q;
    logic       lead;
    logic       trail;
    logic       sample;
    logic       shift;
    logic [2:0] bit_q;
    logic [7:0] rx_sh_q;
    logic [7:0] tx_sh_q;
    logic       loaded_q;

    // leading/trailing depend on idle level, so polarity simply flips the edge sense
    assign lead   = active_i && (sck_i ^ cpol_i) && !(sck_q ^ cpol_i);
    assign trail  = active_i && !(sck_i ^ cpol_i) && (sck_q ^ cpol_i);
    assign sample = cpha_i ? trail : lead;
    assign shift  = cpha_i ? lead : trail;
    // fetch the next byte at the start of each byte time
    assign tx_load_o = active_i && !loaded_q;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sck_q     <= 1'b0;
            bit_q     <= 3'h0;
            rx_sh_q   <= 8'h00;
            tx_sh_q   <= 8'h00;
            loaded_q  <= 1'b0;
            rx_byte_o <= 8'h00;
            rx_done_o <= 1'b0;
            miso_o    <= 1'b0;
        end
        else
        begin
            sck_q     <= sck_i;
            rx_done_o <= 1'b0;
            if (!active_i)
            begin
                bit_q    <= 3'h0;
                loaded_q <= 1'b0;
            end
            else
            begin
                if (tx_load_o)
                begin
                    tx_sh_q  <= tx_byte_i;
                    miso_o   <= lsb_first_i ? tx_byte_i[0] : tx_byte_i[7];
                    loaded_q <= 1'b1;
                end
                // the shift edge at a byte boundary must not push out the fresh byte's first bit
                else if (shift && bit_q != 3'h0)
                begin
                    tx_sh_q <= lsb_first_i ? {1'b0, tx_sh_q[7:1]} : {tx_sh_q[6:0], 1'b0};
                    miso_o  <= lsb_first_i ? tx_sh_q[1] : tx_sh_q[6];
                end
                if (sample)
                begin
                    rx_sh_q <= lsb_first_i ? {mosi_i, rx_sh_q[7:1]} : {rx_sh_q[6:0], mosi_i};
                    bit_q   <= bit_q + 3'h1;
                    if (bit_q == 3'h7)
                    begin
                        rx_byte_o <= lsb_first_i ? {mosi_i, rx_sh_q[7:1]} : {rx_sh_q[6:0], mosi_i};
                        rx_done_o <= 1'b1;
                        loaded_q  <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

// File: rtl/sts_top.sv
/*
 * serial target unit with semaphore and two dma channels into shared ram.
 * assumes an external controller on csn/sck/mosi, and a ram port answering reads
 * one cycle after a granted request; fill characters and pointers come from ports.
 */
`include "sts_regs.svh"

// What this block does
// - all four clock modes via polarity, phase
// - sibling disable leaves settings unchanged
// - two dma channels move bytes alone
// - bytes past tx buffer use fill
// - done event after last ram access
// - cpu takes lock, waits grant, gives
// - give ignored unless cpu owns lock
// - shortcut passes lock to cpu after done
// - rx full event when buffer filled
// - excess rx bytes dropped, overflow set
// - excess tx bytes use fill, flag
// - counts updated at end of transaction
// - enable gives lock to cpu silently
// - take while cpu owns grants at once
// - lock fail ignores whole transaction
// - simultaneous request goes to cpu
// - granted transaction uses both buffers
// - select high releases lock, done event
// - pending cpu take granted after release
// - shortcut plus take serves one grant
// - semaphore never blocks cpu memory access
// - target-out tristate while not selected
module sts_top (
    input  wire logic                   clk_i,
    input  wire logic                   arst_n_i,
    input  wire logic                   enable_i,
    input  wire logic                   cpol_i,
    input  wire logic                   cpha_i,
    input  wire logic                   lsb_first_i,
    input  wire logic                   shortcut_done_take_i,
    input  wire logic             [7:0] tx_underrun_flag_fill_char_i,
    input  wire logic             [7:0] ignored_fill_char_i,
    input  wire logic [`STS_ADDR_W-1:0] rx_buffer_pointer_i,
    input  wire logic [`STS_ADDR_W-1:0] tx_buffer_pointer_i,
    input  wire logic  [`STS_CNT_W-1:0] rx_max_count_i,
    input  wire logic  [`STS_CNT_W-1:0] tx_max_count_i,
    input  wire logic                   take_lock_i,
    input  wire logic                   give_lock_i,
    input  wire logic                   status_clear_i,
    output logic                        lock_granted_o,
    output logic                        xfer_done_o,
    output logic                        rx_full_event_o,
    output logic                        cpu_owns_lock_o,
    output logic                        target_owns_lock_o,
    output logic                        overflow_flag_o,
    output logic                        tx_underrun_flag_o,
    output logic       [`STS_CNT_W-1:0] rx_count_done_o,
    output logic       [`STS_CNT_W-1:0] tx_count_done_o,
    input  wire logic                   csn_i,
    input  wire logic                   sck_i,
    input  wire logic                   mosi_i,
    output logic                        miso_o,
    output logic                        miso_oe_o,
    output logic                        ram_rd_req_o,
    output logic      [`STS_ADDR_W-1:0] ram_rd_addr_o,
    input  wire logic                   ram_rd_gnt_i,
    input  wire logic                   ram_rd_valid_i,
    input  wire logic             [7:0] ram_rd_data_i,
    output logic                        ram_wr_req_o,
    output logic      [`STS_ADDR_W-1:0] ram_wr_addr_o,
    output logic                  [7:0] ram_wr_data_o,
    input  wire logic                   ram_wr_gnt_i
);
    logic                  rst_s1_q;
    logic                  rst_n;
    logic            [2:0] csn_s_q;
    logic            [1:0] sck_s_q;
    logic            [1:0] mosi_s_q;
    logic                  csn_s;
    logic                  csn_fall;
    logic                  csn_rise;
    sts_pkg::sts_sem_type  sem_q;
    sts_pkg::sts_xfer_type xfer_q;
    logic                  enable_q;
    logic                  cpu_pending_q;
    logic                  active;
    logic                  tx_load;
    logic                  rx_done;
    logic            [7:0] rx_byte;
    logic                  sh_miso;
    logic [`STS_CNT_W-1:0] rx_cnt_q;
    logic [`STS_CNT_W-1:0] tx_cnt_q;
    logic [`STS_CNT_W-1:0] rx_push_cnt_q;
    logic            [7:0] tx_byte_q;
    logic                  tx_wait_q;
    logic                  fifo_in_ready;
    logic                  fifo_valid;
    logic            [7:0] fifo_data;
    logic                  fifo_pop;
    logic                  drain_q;
    logic                  grant_cpu;
    logic                  cpu_take;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // pins pass two flops; csn gets a third for edge finding
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            csn_s_q  <= 3'h7;
            sck_s_q  <= 2'h0;
            mosi_s_q <= 2'h0;
        end
        else
        begin
            csn_s_q  <= {csn_s_q[1:0], csn_i};
            sck_s_q  <= {sck_s_q[0], sck_i};
            mosi_s_q <= {mosi_s_q[0], mosi_i};
        end
    end

    assign csn_s    = csn_s_q[1];
    assign csn_fall = enable_q && csn_s_q[2] && !csn_s;
    assign csn_rise = !csn_s_q[2] && csn_s;
    assign active   = (xfer_q != sts_pkg::XF_IDLE) && !csn_s;

    // ignored unless target won the lock
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xfer_q <= sts_pkg::XF_IDLE;
        end
        else
        begin
            case (xfer_q)
                sts_pkg::XF_IDLE:
                begin
                    if (csn_fall && sem_q == sts_pkg::SEM_FREE && !cpu_take)
                    begin
                        xfer_q <= sts_pkg::XF_GRANTED;
                    end
                    else if (csn_fall)
                    begin
                        xfer_q <= sts_pkg::XF_IGNORED;
                    end
                end
                sts_pkg::XF_GRANTED:
                begin
                    if (csn_rise)
                    begin
                        xfer_q <= sts_pkg::XF_IDLE;
                    end
                end
                default:
                begin
                    if (csn_rise)
                    begin
                        xfer_q <= sts_pkg::XF_IDLE;
                    end
                end
            endcase
        end
    end

    // done waits for the rx fifo to drain so ram is no longer touched
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drain_q <= 1'b0;
        end
        else if (xfer_q == sts_pkg::XF_GRANTED && csn_rise)
        begin
            drain_q <= 1'b1;
        end
        else if (drain_q && !fifo_valid && !tx_wait_q)
        begin
            drain_q <= 1'b0;
        end
    end

    assign cpu_take  = take_lock_i || cpu_pending_q;
    assign grant_cpu = drain_q && !fifo_valid && !tx_wait_q;

    // semaphore; settings are ports, untouched by enable
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sem_q          <= sts_pkg::SEM_FREE;
            enable_q       <= 1'b0;
            cpu_pending_q  <= 1'b0;
            lock_granted_o <= 1'b0;
            xfer_done_o    <= 1'b0;
        end
        else
        begin
            enable_q       <= enable_i;
            lock_granted_o <= 1'b0;
            xfer_done_o    <= 1'b0;
            if (!enable_i)
            begin
                sem_q         <= sts_pkg::SEM_FREE;
                cpu_pending_q <= 1'b0;
            end
            else if (!enable_q)
            begin
                sem_q <= sts_pkg::SEM_CPU;
            end
            else
            begin
                case (sem_q)
                    sts_pkg::SEM_CPU:
                    begin
                        // take while owned grants at once
                        if (take_lock_i)
                        begin
                            lock_granted_o <= 1'b1;
                        end
                        // give frees it for the target
                        else if (give_lock_i)
                        begin
                            sem_q <= sts_pkg::SEM_FREE;
                        end
                    end
                    sts_pkg::SEM_FREE:
                    begin
                        if (take_lock_i)
                        begin
                            sem_q          <= sts_pkg::SEM_CPU;
                            lock_granted_o <= 1'b1;
                        end
                        else if (csn_fall)
                        begin
                            sem_q <= sts_pkg::SEM_TARGET;
                        end
                    end
                    default:
                    begin
                        if (take_lock_i)
                        begin
                            cpu_pending_q <= 1'b1;
                        end
                        // release on select high, done event
                        if (grant_cpu)
                        begin
                            xfer_done_o   <= 1'b1;
                            cpu_pending_q <= 1'b0;
                            // one grant for shortcut plus take
                            if (shortcut_done_take_i || cpu_pending_q || take_lock_i)
                            begin
                                sem_q          <= sts_pkg::SEM_CPU;
                                lock_granted_o <= 1'b1;
                            end
                            else
                            begin
                                sem_q <= sts_pkg::SEM_FREE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign cpu_owns_lock_o    = (sem_q == sts_pkg::SEM_CPU);
    assign target_owns_lock_o = (sem_q == sts_pkg::SEM_TARGET);

    // shifter waits until the first byte is back from ram, else it loads a stale byte
    // mode taken from polarity and phase
    sts_shifter u_shifter (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n),
        .active_i    (active && !(tx_wait_q && tx_cnt_q == '0)),
        .sck_i       (sck_s_q[1]),
        .mosi_i      (mosi_s_q[1]),
        .cpol_i      (cpol_i),
        .cpha_i      (cpha_i),
        .lsb_first_i (lsb_first_i),
        .tx_byte_i   (tx_byte_q),
        .tx_load_o   (tx_load),
        .miso_o      (sh_miso),
        .rx_byte_o   (rx_byte),
        .rx_done_o   (rx_done)
    );

    assign miso_oe_o = active;
    assign miso_o    = sh_miso;

    // tx prefetch: next byte is fetched right after the shifter loads the current one
    // reader channel fetches without cpu
    // extra tx bytes flagged and filled
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_byte_q          <= `STS_FILL_RESET;
            tx_cnt_q           <= '0;
            tx_wait_q          <= 1'b0;
            ram_rd_req_o       <= 1'b0;
            ram_rd_addr_o      <= '0;
            tx_underrun_flag_o <= 1'b0;
        end
        else
        begin
            if (csn_fall)
            begin
                tx_cnt_q <= '0;
                if (sem_q == sts_pkg::SEM_FREE && !cpu_take && tx_max_count_i != '0)
                begin
                    ram_rd_req_o  <= 1'b1;
                    ram_rd_addr_o <= tx_buffer_pointer_i;
                    tx_wait_q     <= 1'b1;
                end
                else if (sem_q == sts_pkg::SEM_FREE && !cpu_take)
                begin
                    tx_byte_q <= tx_underrun_flag_fill_char_i;
                end
                else
                begin
                    tx_byte_q <= ignored_fill_char_i;
                end
            end
            else if (ram_rd_req_o && ram_rd_gnt_i)
            begin
                ram_rd_req_o <= 1'b0;
            end
            if (tx_wait_q && ram_rd_valid_i)
            begin
                tx_byte_q <= ram_rd_data_i;
                tx_cnt_q  <= tx_cnt_q + 1'b1;
                tx_wait_q <= 1'b0;
            end
            else if (tx_load && xfer_q == sts_pkg::XF_GRANTED)
            begin
                if (tx_cnt_q < tx_max_count_i && !tx_wait_q)
                begin
                    ram_rd_req_o  <= 1'b1;
                    ram_rd_addr_o <= tx_buffer_pointer_i + `STS_ADDR_W'(tx_cnt_q);
                    tx_wait_q     <= 1'b1;
                end
                else
                begin
                    tx_byte_q          <= tx_underrun_flag_fill_char_i;
                    tx_underrun_flag_o <= tx_underrun_flag_o || (tx_cnt_q >= tx_max_count_i);
                end
            end
            else if (status_clear_i)
            begin
                tx_underrun_flag_o <= 1'b0;
            end
        end
    end

    // excess rx bytes dropped, overflow set
    // rx full once the limit is reached
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_cnt_q        <= '0;
            overflow_flag_o <= 1'b0;
            rx_full_event_o <= 1'b0;
        end
        else
        begin
            rx_full_event_o <= 1'b0;
            if (csn_fall)
            begin
                rx_cnt_q <= '0;
            end
            else if (rx_done && xfer_q == sts_pkg::XF_GRANTED)
            begin
                if (rx_cnt_q < rx_max_count_i && fifo_in_ready)
                begin
                    rx_cnt_q        <= rx_cnt_q + 1'b1;
                    rx_full_event_o <= (rx_cnt_q + 1'b1 == rx_max_count_i);
                end
                else
                begin
                    overflow_flag_o <= 1'b1;
                end
            end
            else if (status_clear_i)
            begin
                overflow_flag_o <= 1'b0;
            end
        end
    end

    sts_fifo #(
        .WIDTH (8),
        .DEPTH (`STS_FIFO_DEPTH),
        .AW    (`STS_FIFO_AW)
    ) u_rx_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n),
        .flush_i     (1'b0),
        .in_data_i   (rx_byte),
        .in_valid_i  (rx_done && xfer_q == sts_pkg::XF_GRANTED && rx_cnt_q < rx_max_count_i),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    // writer channel; cpu ram access is never gated here
    assign ram_wr_req_o  = fifo_valid;
    assign ram_wr_data_o = fifo_data;
    assign ram_wr_addr_o = rx_buffer_pointer_i + `STS_ADDR_W'(rx_push_cnt_q);
    assign fifo_pop      = ram_wr_gnt_i;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_push_cnt_q <= '0;
        end
        else if (csn_fall)
        begin
            rx_push_cnt_q <= '0;
        end
        else if (fifo_valid && fifo_pop)
        begin
            rx_push_cnt_q <= rx_push_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_count_done_o <= '0;
            tx_count_done_o <= '0;
        end
        else if (grant_cpu)
        begin
            rx_count_done_o <= rx_push_cnt_q;
            tx_count_done_o <= tx_cnt_q;
        end
    end
endmodule

// File: testbench/sts_top_asserts.sv
/* assertions on the ports of sts_top.
   assumes one clock domain and the bind below. */
module sts_chk (
    input logic clk_i,
    input logic arst_n_i,
    input logic enable_i,
    input logic take_lock_i,
    input logic give_lock_i,
    input logic shortcut_done_take_i,
    input logic csn_i,
    input logic lock_granted_o,
    input logic xfer_done_o,
    input logic cpu_owns_lock_o,
    input logic target_owns_lock_o,
    input logic miso_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_gnt; take_lock_i && cpu_owns_lock_o |=> lock_granted_o; endproperty
    a_gnt: assert property (p_gnt) else $error("no grant"); // at once
    property p_own; lock_granted_o |-> ##[0:1] cpu_owns_lock_o; endproperty
    a_own: assert property (p_own) else $error("not owner"); // owner
    property p_give;
        give_lock_i && !take_lock_i && !cpu_owns_lock_o && !target_owns_lock_o |=> !cpu_owns_lock_o;
    endproperty
    a_give: assert property (p_give) else $error("give used"); // ignored
    property p_done; xfer_done_o |=> !target_owns_lock_o; endproperty
    a_done: assert property (p_done) else $error("lock kept"); // release
    property p_short; xfer_done_o && shortcut_done_take_i |-> ##[0:2] cpu_owns_lock_o; endproperty
    a_short: assert property (p_short) else $error("no handover"); // handover
    property p_once; lock_granted_o |=> !lock_granted_o; endproperty
    a_once: assert property (p_once) else $error("two grants"); // one grant
    property p_en; $rose(enable_i) |-> !lock_granted_o [*4]; endproperty
    a_en: assert property (p_en) else $error("grant on enable"); // silent
    property p_oe; csn_i [*5] |-> !miso_oe_o; endproperty
    a_oe: assert property (p_oe) else $error("driven idle"); // released
endmodule
bind sts_top sts_chk i_chk (.*);

// File: testbench/sts_spi_ctrl.sv
/* spi controller model: select, clock and out data.
   assumes a 125 ns serial clock and three-byte frames. */
module sts_spi_ctrl (
    output logic      csn_o,
    output logic      sck_o,
    output logic      mosi_o,
    input  wire logic miso_i,
    input  wire logic cpol_i,
    input  wire logic cpha_i
);
    timeunit 1ns / 100ps;
    initial {csn_o, sck_o, mosi_o} = 3'b100;
    task automatic run(input logic [23:0] tx, output logic [23:0] rx);
        sck_o = cpol_i;
        #100 csn_o = 1'b0;
        #600;
        for (int i = 23; i >= 0; i--)
        begin
            mosi_o = cpha_i ? mosi_o : tx[i];
            #62.5 sck_o = ~sck_o;
            {mosi_o, rx[i]} = cpha_i ? {tx[i], rx[i]} : {mosi_o, miso_i};
            #62.5 sck_o = ~sck_o;
            rx[i] = cpha_i ? miso_i : rx[i];
        end
        // released data flips so a stale level never passes
        #100 csn_o = 1'b1;
        mosi_o = ~mosi_o;
    endtask
endmodule

// File: testbench/test_sts_top.sv
/* bench for sts_top: lock tasks, controller model, stalling ram.
   assumes the checker binds itself. */
`define CMP(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module test_sts_top;
    timeunit 1ns / 100ps;
    logic clk_i = 0, arst_n_i = 0, enable_i = 0, cpol_i = 0, cpha_i = 0, lsb_first_i = 0, csn_i, sck_i, mosi_i;
    logic shortcut_done_take_i = 0, take_lock_i = 0, give_lock_i = 0, status_clear_i = 0, miso_o, miso_oe_o;
    logic ram_rd_gnt_i = 0, ram_wr_gnt_i = 0, ram_rd_valid_i = 0, ram_rd_req_o, ram_wr_req_o, lock_granted_o;
    logic xfer_done_o, rx_full_event_o, cpu_owns_lock_o, target_owns_lock_o, overflow_flag_o, tx_underrun_flag_o;
    logic [7:0] tx_underrun_flag_fill_char_i = 8'h5a, ignored_fill_char_i = 8'hc3, ram_rd_data_i = 0, ram_wr_data_o;
    logic [31:0] rx_buffer_pointer_i = 0, tx_buffer_pointer_i = 0, ram_rd_addr_o, ram_wr_addr_o;
    logic [12:0] rx_max_count_i = 13'h2, tx_max_count_i = 13'h2, rx_count_done_o, tx_count_done_o;
    logic [23:0] rx;
    wire miso_w = miso_oe_o ? miso_o : 1'bz;
    int checks = 0, n_mismatch = 0, n_wr, n_full, n_done, n_gnt = 0;
    always #2 clk_i = ~clk_i;
    sts_top i_dut (.*);
    sts_spi_ctrl i_ctrl (.csn_o(csn_i), .sck_o(sck_i), .mosi_o(mosi_i), .miso_i(miso_w), .cpol_i, .cpha_i);
    // grants alternate so both channels stall
    always @(posedge clk_i)
    begin
        {ram_rd_gnt_i, ram_wr_gnt_i} <= {~ram_rd_gnt_i, ram_rd_gnt_i};
        {ram_rd_valid_i, ram_rd_data_i} <= {ram_rd_req_o && ram_rd_gnt_i, ram_rd_addr_o[7:0]};
        n_full += int'(rx_full_event_o === 1'b1);
        n_done += int'(xfer_done_o === 1'b1);
        n_gnt += int'(lock_granted_o === 1'b1);
        if (ram_wr_req_o && ram_wr_gnt_i)
        begin
            `CMP({ram_wr_addr_o, ram_wr_data_o}, {rx_buffer_pointer_i + n_wr, 8'h30 + 8'(n_wr)}) // in order
            n_wr++;
        end
    end
    task automatic ctl(input logic [2:0] tgc);
        @(posedge clk_i);
        {take_lock_i, give_lock_i, status_clear_i} <= tgc;
        @(posedge clk_i);
        {take_lock_i, give_lock_i, status_clear_i} <= 3'h0;
        #1;
    endtask
    task automatic frame(input logic [7:0] f, input logic g);
        logic [7:0] p = tx_buffer_pointer_i[7:0];
        {n_wr, n_full, n_done} = '0;
        i_ctrl.run(24'h30_3132, rx);
        for (int w = 0; w < 200 && n_done == 0; w++)
            @(posedge clk_i);
        #5;
        `CMP({rx, n_wr[3:0], n_full[3:0], n_done[3:0]}, g ? {p, p + 8'h1, f, 12'h211} : {f, f, f, 12'h0}) // fill
        `CMP({overflow_flag_o, tx_underrun_flag_o, rx_count_done_o, tx_count_done_o}, {g, g, 13'h2, 13'h2}) // counts
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        enable_i <= 1'b1;
        ctl(3'h0);
        `CMP({cpu_owns_lock_o, target_owns_lock_o}, 2'b10) // cpu first
        for (int m = 0; m < 4; m++)
        begin
            {cpol_i, cpha_i, shortcut_done_take_i} <= {2'(m), m[0]};
            {tx_buffer_pointer_i, rx_buffer_pointer_i} <= {32'(m * 16), 32'(m * 16 + 256)};
            ctl(3'h5); // take
            ctl(3'h2); // give
            ctl(3'h2); // stray give
            frame(tx_underrun_flag_fill_char_i, 1'b1); // tx_underrun_flag
        end
        ctl(3'h5);
        frame(ignored_fill_char_i, 1'b0); // ignored
        `CMP(n_gnt, 7) // one grant per take or handover, none on enable
        tally_and_finish();
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #100us n_mismatch++;
        tally_and_finish();
    end
endmodule
